// ==== verilog/cpd_pkg.sv ====
// Package for the charger port detection and mode control block
// ==========================================================================
// How it works
// RL1: Port detection runs before select pins at power-up
// RL2: Select pins ignored until detection done, then change
// RL3: Pin change updates droop threshold with current limit
// RL4: Host mode uses host registers, default uses resets
// RL5: Supply good: host mode if command seen, else default
// RL6: Stand-alone limit comes from the two select pins
// RL7: Watchdog expiry leaves host mode, reloads defaults
// RL8: No accessory adapter detection; such ports get 500mA (code still reports them as ACA port type)
// RL9: Automatic detection only in stand-alone mode
// RL10: Force-detect bit makes detection run on next insertion
// RL11: Detection machine has six states
// RL12: Insertion outside host mode or force bit enters contact detect
// RL13: Contact timer expiry goes to non-standard check, else primary
// RL14: Primary picks one of two secondary paths
// RL15: Non-standard pass goes to configuration, else primary
// RL16: Secondary classification advances to configuration
// RL17: Configuration sets current limit and charge timer
// RL18: Unconnected charging and standard ports draw at most 100mA
// RL19: D+ source driven during battery wake-up
// RL20: Clear bit stops the D+ source
// RL21: System connects to upstream host within one second
// RL22: Power good stays released until detection completes
// RL23: Detected type and limits held until next insertion or force
package cpd_pkg;
    // ======================================================================
    // Register map
    localparam logic [7:0] CPD_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] CPD_ADDR_DPLUS  = 8'h07;
    localparam logic [7:0] CPD_ADDR_HOST   = 8'h10;
    localparam logic [7:0] CPD_ADDR_STATUS = 8'h14;
    localparam logic [7:0] CPD_ADDR_LIMIT  = 8'h18;
    localparam int         CPD_BIT_FORCE   = 4;
    localparam int         CPD_BIT_CLRDP   = 4;
    localparam int         CPD_BIT_HCMD    = 0;
    localparam int         CPD_BIT_WDEN    = 1;
    localparam int         CPD_BIT_WDKICK  = 2;
    localparam logic [2:0] CPD_HOST_RESET  = 3'h2;

    // ======================================================================
    // Current limit codes
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_100  = 3'h0;
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_500  = 3'h1;
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_900  = 3'h2;
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_1500 = 3'h3;
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_2000 = 3'h4;
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_EXT  = 3'h5;
    localparam logic [2:0] CPD_INPUT_CURRENT_LIMIT_RESET = CPD_INPUT_CURRENT_LIMIT_500;
    localparam logic [1:0] CPD_TMR_RESET  = 2'h1;
    localparam logic [1:0] CPD_DROOP_RESET = 2'h0;

    // ======================================================================
    // Timing
    localparam int CPD_CLK_HZ      = 25_000_000;
    localparam int CPD_DCD_MS      = 600;
    localparam int CPD_WDOG_MS     = 50_000;
    localparam int CPD_DCD_CYCLES  = CPD_CLK_HZ / 1000 * CPD_DCD_MS;
    localparam int CPD_WDOG_CYCLES = 32'd1_250_000_000;

    // ======================================================================
    // Types
    typedef enum logic [2:0] {
        CPD_IDLE, CPD_DCD, CPD_PRIMARY, CPD_SECONDARY, CPD_NONSTD, CPD_CONFIG
    } cpd_state_type;

    typedef enum logic [2:0] {
        CPD_PORT_NONE, CPD_PORT_SDP, CPD_PORT_CDP, CPD_PORT_DCP, CPD_PORT_NSA, CPD_PORT_ACA
    } cpd_port_type;

    typedef struct packed {
        logic [2:0] input_current_limit;
        logic [1:0] input_voltage_droop_threshold;
        logic [1:0] charge_timer;
    } cpd_limits_type;

    function automatic cpd_limits_type cpd_pins_limits(input logic [1:0] sel);
        cpd_limits_type l;
        l.charge_timer = CPD_TMR_RESET;
        unique case (sel)
            2'h0: begin l.input_current_limit = CPD_INPUT_CURRENT_LIMIT_100;  l.input_voltage_droop_threshold = 2'h0; end
            2'h1: begin l.input_current_limit = CPD_INPUT_CURRENT_LIMIT_500;  l.input_voltage_droop_threshold = 2'h1; end
            2'h2: begin l.input_current_limit = CPD_INPUT_CURRENT_LIMIT_EXT;  l.input_voltage_droop_threshold = 2'h2; end
            2'h3: begin l.input_current_limit = CPD_INPUT_CURRENT_LIMIT_EXT;  l.input_voltage_droop_threshold = 2'h3; end
        endcase
        return l;
    endfunction
endpackage

// ==== verilog/cpd_ctrl.sv ====
// Charger port detection and host/default mode control
`timescale 1ns/100ps
module cpd_ctrl
    import cpd_pkg::*;
#(
    parameter int DCD_CYCLES  = CPD_DCD_CYCLES,
    parameter int WDOG_CYCLES = CPD_WDOG_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Pins and analog comparators
    input  wire logic        input_current_limit_select_a,
    input  wire logic        input_current_limit_select_b,
    input  wire logic        supply_good,
    input  wire logic        battery_good,
    input  wire logic        data_contact,
    input  wire logic        primary_hit,
    input  wire logic        secondary_hit,
    input  wire logic        nonstd_pass,
    input  wire logic        aca_seen,
    // Results
    output logic [2:0]       input_current_limit,
    output logic [1:0]       input_voltage_droop_threshold,
    output logic [1:0]       charge_timer,
    output logic [2:0]       port_type,
    output logic             host_mode,
    output logic             dplus_source_en,
    output logic             power_good_n_o,
    output logic             power_good_n_oe
);
    // ======================================================================
    // Synchronisers
    logic [8:0] meta_q, sync_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {input_current_limit_select_a, input_current_limit_select_b, supply_good, battery_good, data_contact,
                       primary_hit, secondary_hit, nonstd_pass, aca_seen};
            sync_q <= meta_q;
        end
    end
    logic [1:0] sel_s;
    logic       vbus_s, batt_s, contact_s, prim_s, sec_s, nsa_s, aca_s;
    assign {sel_s, vbus_s, batt_s, contact_s, prim_s, sec_s, nsa_s, aca_s} = sync_q;

    // ======================================================================
    // Bus slave, one wait state, ack drops after one cycle
    logic        wr_en, rd_en;
    logic        force_q, clr_dp_q, hcmd_q, wden_q;
    logic [2:0]  host_input_current_limit_q;
    logic        kick;
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign kick  = wr_en && wb_adr_i == CPD_ADDR_HOST && wb_dat_i[CPD_BIT_WDKICK];

    cpd_state_type state_q;
    logic          detect_done_q, start_detect;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= rd_en;
            if (rd_en) begin
                unique case (wb_adr_i)
                    CPD_ADDR_CTRL:   wb_dat_o <= {27'h0, force_q, 4'h0};
                    CPD_ADDR_DPLUS:  wb_dat_o <= {27'h0, clr_dp_q, 4'h0};
                    CPD_ADDR_HOST:   wb_dat_o <= {26'h0, host_input_current_limit_q, 1'b0, wden_q, hcmd_q};
                    CPD_ADDR_STATUS: wb_dat_o <= {24'h0, dplus_source_en, host_mode, detect_done_q,
                                                  port_type, 2'h0};
                    CPD_ADDR_LIMIT:  wb_dat_o <= {25'h0, charge_timer, input_voltage_droop_threshold,
                                                  input_current_limit};
                    default:         wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ======================================================================
    // Host registers
    logic wdog_exp;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hcmd_q      <= 1'b0;
            wden_q      <= 1'b1;
            host_input_current_limit_q <= CPD_HOST_RESET;
        end else if (wdog_exp) begin
            hcmd_q      <= 1'b0;           // [RL7]
            host_input_current_limit_q <= CPD_HOST_RESET; // [RL7]
        end else if (wr_en && wb_adr_i == CPD_ADDR_HOST) begin
            hcmd_q      <= 1'b1;           // Any host write counts as a command [RL5]
            wden_q      <= wb_dat_i[CPD_BIT_WDEN];
            host_input_current_limit_q <= wb_dat_i[5:3];
        end else if (wr_en) begin
            hcmd_q      <= 1'b1;           // [RL5]
        end
    end

    // Force bit: set by host, cleared when detection starts; set wins [RL10]
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            force_q <= 1'b0;
        end else if (wr_en && wb_adr_i == CPD_ADDR_CTRL && wb_dat_i[CPD_BIT_FORCE]) begin
            force_q <= 1'b1;               // [RL10]
        end else if (start_detect) begin
            force_q <= 1'b0;
        end
    end

    // D+ source clear bit; cleared again on a new insertion
    logic vbus_q, insert;
    assign insert = vbus_s && !vbus_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            clr_dp_q <= 1'b0;
        end else if (wr_en && wb_adr_i == CPD_ADDR_DPLUS && wb_dat_i[CPD_BIT_CLRDP] && batt_s) begin
            clr_dp_q <= 1'b1;              // Only honoured once battery is good [RL20]
        end else if (insert) begin
            clr_dp_q <= 1'b0;
        end
    end

    // ======================================================================
    // Watchdog
    logic [31:0] wd_cnt_q;
    // A write in the expiry cycle keeps host mode alive; the command wins
    assign wdog_exp = wden_q && hcmd_q && !wr_en && wd_cnt_q == 32'(WDOG_CYCLES - 1);
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !hcmd_q || kick || wr_en) begin
            wd_cnt_q <= '0;
        end else if (wden_q) begin
            wd_cnt_q <= wd_cnt_q + 32'h1;
        end
    end

    // Mode follows supply or battery good and command seen [RL4] [RL5]
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            host_mode <= 1'b0;
        end else begin
            host_mode <= (vbus_s || batt_s) && hcmd_q && !wdog_exp; // [RL5] [RL7]
        end
    end

    // ======================================================================
    // Detection machine
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            vbus_q <= 1'b0;
        end else begin
            vbus_q <= vbus_s;
        end
    end
    // Automatic only outside host mode; force bit works in both modes [RL9] [RL12]
    assign start_detect = state_q == CPD_IDLE && ((insert && !host_mode) || (force_q && insert));

    logic [31:0]  dcd_cnt_q;
    logic         to_dcp_path_q;
    cpd_port_type port_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_q != CPD_DCD) begin
            dcd_cnt_q <= '0;
        end else begin
            dcd_cnt_q <= dcd_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q       <= CPD_IDLE;
            to_dcp_path_q <= 1'b0;
            port_q        <= CPD_PORT_NONE;
        end else if (!vbus_s) begin
            state_q <= CPD_IDLE;
        end else begin
            unique case (state_q) // [RL11]
                CPD_IDLE: if (start_detect) begin
                    state_q <= CPD_DCD; // [RL1] [RL12]
                end
                CPD_DCD: if (dcd_cnt_q == 32'(DCD_CYCLES - 1)) begin
                    state_q <= CPD_NONSTD;  // [RL13]
                end else if (contact_s) begin
                    state_q <= CPD_PRIMARY; // [RL13]
                end
                CPD_PRIMARY: begin
                    to_dcp_path_q <= prim_s; // [RL14]
                    state_q       <= CPD_SECONDARY;
                end
                CPD_SECONDARY: begin
                    // Accessory adapters are reported as ACA ahead of other types; they fall to 500mA [RL8]
                    if (aca_s) port_q <= CPD_PORT_ACA;
                    else if (to_dcp_path_q) port_q <= sec_s ? CPD_PORT_DCP : CPD_PORT_CDP;
                    else port_q <= sec_s ? CPD_PORT_NSA : CPD_PORT_SDP;
                    state_q <= CPD_CONFIG; // [RL16]
                end
                CPD_NONSTD: if (nsa_s) begin
                    port_q  <= CPD_PORT_NSA;
                    state_q <= CPD_CONFIG;  // [RL15]
                end else begin
                    state_q <= CPD_PRIMARY; // [RL15]
                end
                CPD_CONFIG: state_q <= CPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || start_detect) begin
            detect_done_q <= 1'b0;
        end else if (state_q == CPD_CONFIG) begin
            detect_done_q <= 1'b1;
        end
    end

    // ======================================================================
    // Limit selection
    logic [1:0] sel_q;
    logic       pins_armed_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_s;
        end
    end
    // Pins arm only on a change after detection finished [RL2]
    always_ff @(posedge clk_sys) begin
        if (!reset_n || start_detect) begin
            pins_armed_q <= 1'b0;
        end else if (detect_done_q && sel_s != sel_q) begin
            pins_armed_q <= 1'b1; // [RL2]
        end
    end

    cpd_limits_type lim_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            lim_q <= '{CPD_INPUT_CURRENT_LIMIT_RESET, CPD_DROOP_RESET, CPD_TMR_RESET};
        end else if (wdog_exp) begin
            lim_q <= '{CPD_INPUT_CURRENT_LIMIT_RESET, CPD_DROOP_RESET, CPD_TMR_RESET}; // [RL7]
        end else if (state_q == CPD_CONFIG) begin
            // Unconnected SDP/CDP get 100mA; releasing D+ does not raise it [RL17] [RL18]
            unique case (port_q)
                CPD_PORT_DCP: lim_q <= '{CPD_INPUT_CURRENT_LIMIT_1500, CPD_DROOP_RESET, 2'h2};
                CPD_PORT_CDP: lim_q <= '{CPD_INPUT_CURRENT_LIMIT_100, CPD_DROOP_RESET, 2'h2};
                CPD_PORT_SDP: lim_q <= '{CPD_INPUT_CURRENT_LIMIT_100, CPD_DROOP_RESET, 2'h3};
                CPD_PORT_NSA: lim_q <= '{CPD_INPUT_CURRENT_LIMIT_500, CPD_DROOP_RESET, 2'h1};
                default:      lim_q <= '{CPD_INPUT_CURRENT_LIMIT_500, CPD_DROOP_RESET, 2'h1}; // [RL8]
            endcase
        end else if (pins_armed_q && !host_mode) begin
            lim_q <= cpd_pins_limits(sel_s); // [RL3] [RL6]
        end
        // Otherwise held [RL23]
    end

    // ======================================================================
    // Outputs
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            input_current_limit           <= CPD_INPUT_CURRENT_LIMIT_RESET;
            input_voltage_droop_threshold <= CPD_DROOP_RESET;
            charge_timer                  <= CPD_TMR_RESET;
            port_type                     <= '0;
            dplus_source_en               <= 1'b0;
            power_good_n_o                <= 1'b0;
            power_good_n_oe               <= 1'b0;
        end else begin
            input_current_limit           <= host_mode ? host_input_current_limit_q : lim_q.input_current_limit; // [RL4]
            input_voltage_droop_threshold <= lim_q.input_voltage_droop_threshold;
            charge_timer                  <= lim_q.charge_timer;
            port_type                     <= port_q;
            // Drive D+ during wake-up until host clears it [RL19] [RL20]
            dplus_source_en <= vbus_s && detect_done_q && !clr_dp_q &&
                               (port_q == CPD_PORT_SDP || port_q == CPD_PORT_CDP);
            power_good_n_o  <= 1'b0;
            power_good_n_oe <= detect_done_q && vbus_s; // [RL22]
        end
    end
endmodule

// ==== tb/cpd_ctrl_sva.sv ====
// Assertion checker for the port detection and mode control block
`timescale 1ns/100ps
module cpd_ctrl_sva
    import cpd_pkg::*;
#(
    parameter int DCD_CYCLES  = 20,
    parameter int WDOG_CYCLES = 50
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_ack_o,
    input wire logic        supply_good,
    input wire logic        battery_good,
    input wire logic [2:0]  input_current_limit,
    input wire logic [1:0]  charge_timer,
    input wire logic [2:0]  port_type,
    input wire logic        host_mode,
    input wire logic        dplus_source_en,
    input wire logic        power_good_n_oe
);
    // ======================================================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic wr_dp;
    // Clear-D+ write, seen at the edge that completes it
    assign wr_dp = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == CPD_ADDR_DPLUS && wb_dat_i[CPD_BIT_CLRDP];
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    AST_RST_DFLT: assert property ($rose(reset_n) |->
        input_current_limit == CPD_INPUT_CURRENT_LIMIT_RESET && charge_timer == CPD_TMR_RESET && !host_mode)
        else $error("reset defaults wrong");
    AST_PG_HELD: assert property (power_good_n_oe |-> port_type != CPD_PORT_NONE)
        else $error("power good pulled before detection");
    AST_DCP_SET: assert property (!host_mode && $changed(port_type) && port_type == CPD_PORT_DCP |->
        ##[0:1] (input_current_limit == CPD_INPUT_CURRENT_LIMIT_1500 && charge_timer == 2'h2))
        else $error("dedicated port limits wrong");
    AST_DBP_LOW: assert property (!host_mode && $changed(port_type) &&
        (port_type == CPD_PORT_SDP || port_type == CPD_PORT_CDP) |-> ##[0:1] input_current_limit == CPD_INPUT_CURRENT_LIMIT_100)
        else $error("downstream port limit not 100mA");
    AST_ADAPT: assert property (!host_mode && $changed(port_type) &&
        (port_type == CPD_PORT_NSA || port_type == CPD_PORT_ACA) |->
        ##[0:1] (input_current_limit == CPD_INPUT_CURRENT_LIMIT_500 && charge_timer == 2'h1))
        else $error("adapter limit not 500mA");
    AST_HOST_DROP: assert property ((!supply_good && !battery_good)[*5] |-> !host_mode)
        else $error("host mode without good supply");
    AST_HOST_SET: assert property ((supply_good || battery_good)[*5] ##0 wr_dp |=> ##[0:2] host_mode)
        else $error("host mode not entered after write");
    AST_DP_CLR: assert property (battery_good[*5] ##0 wr_dp |=> ##[0:2] !dplus_source_en)
        else $error("D+ source not stopped");
endmodule
bind cpd_ctrl cpd_ctrl_sva #(.DCD_CYCLES(DCD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_cpd_ctrl_sva (
    .clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o,
    .supply_good, .battery_good, .input_current_limit, .charge_timer, .port_type, .host_mode,
    .dplus_source_en, .power_good_n_oe);

// ==== tb/cpd_port_model.sv ====
// Model of the USB port or adapter on the data lines
`timescale 1ns/100ps
module cpd_port_model
    import cpd_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       attach,
    input wire logic [2:0] kind,
    output logic           supply_good,
    output logic           data_contact,
    output logic           primary_hit,
    output logic           secondary_hit,
    output logic           nonstd_pass,
    output logic           aca_seen
);
    // ======================================================================
    // Line behaviour
    logic [3:0] age_q;
    // Contact settles late; released lines fall to their pull-downs
    always_ff @(posedge clk_sys) begin
        age_q <= !attach ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
    end
    assign supply_good   = attach;
    // Non-standard adapters never show contact, so the timer must run out
    assign data_contact  = attach && kind != CPD_PORT_NSA && age_q > 4'h4;
    assign primary_hit   = attach && (kind == CPD_PORT_DCP || kind == CPD_PORT_CDP);
    assign secondary_hit = attach && kind == CPD_PORT_DCP;
    assign nonstd_pass   = attach && kind == CPD_PORT_NSA;
    assign aca_seen      = attach && kind == CPD_PORT_ACA;
endmodule

// ==== tb/cpd_ctrl_tb.sv ====
// Testbench for the port detection and mode control block
`timescale 1ns/100ps
module cpd_ctrl_tb
    import cpd_pkg::*;
;
    // ======================================================================
    // Signals
    logic clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0] wb_sel_i;
    logic input_current_limit_select_a, input_current_limit_select_b, battery_good, attach, host_mode, dplus_source_en;
    logic supply_good, data_contact, primary_hit, secondary_hit, nonstd_pass, aca_seen;
    logic [2:0] kind, input_current_limit, port_type;
    logic [1:0] input_voltage_droop_threshold, charge_timer;
    logic power_good_n_o, power_good_n_oe;
    int err_count, samples_checked, n;
    logic [2:0] kinds [5] = '{CPD_PORT_DCP, CPD_PORT_CDP, CPD_PORT_SDP, CPD_PORT_NSA, CPD_PORT_ACA};
    logic [2:0] ilims [5] = '{CPD_INPUT_CURRENT_LIMIT_1500, CPD_INPUT_CURRENT_LIMIT_100, CPD_INPUT_CURRENT_LIMIT_100, CPD_INPUT_CURRENT_LIMIT_500, CPD_INPUT_CURRENT_LIMIT_500};
    logic [1:0] tmrs [5] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h1};
    cpd_ctrl #(.DCD_CYCLES(20), .WDOG_CYCLES(50)) u_cpd_ctrl (.*);
    cpd_port_model u_cpd_port_model (.*);
    always #20 clk_sys = ~clk_sys;
    // ======================================================================
    // Tasks
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_out(input logic [7:0] g, input logic [7:0] e);
        chk_reg({24'h0, g}, {24'h0, e});
    endtask
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask
    task wait_for(input logic [2:0] t);
        n = 0;
        while (port_type !== t && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        if (port_type !== t) begin
            err_count++;
            close_out();
        end
    endtask
    // ======================================================================
    // Sequence
    initial begin
        {clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, battery_good, attach} = '0;
        {wb_adr_i, wb_dat_i, kind} = '0;
        wb_sel_i = 4'hf;
        {input_current_limit_select_a, input_current_limit_select_b} = 2'h3;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        wb(CPD_ADDR_LIMIT, 1'b0, 32'h0); chk_reg(q, 32'h21);
        wb(CPD_ADDR_HOST, 1'b0, 32'h0); chk_reg(q, 32'h12);
        wb(8'hfc, 1'b0, 32'h0); chk_reg(q, 32'h0);
        chk_out(power_good_n_oe, 8'h0);
        $display("reset test done");
        // Select pins held high from power up must not override detection
        for (int i = 0; i < 5; i++) begin
            kind <= kinds[i];
            attach <= 1'b1;
            wait_for(kinds[i]);
            repeat (2) @(posedge clk_sys);
            chk_out(input_current_limit, ilims[i]);
            chk_out(charge_timer, tmrs[i]);
            chk_out({power_good_n_oe, power_good_n_o}, 8'h2);
            if (i == 2) chk_out(dplus_source_en, 8'h1);
            if (i < 4) begin
                attach <= 1'b0;
                repeat (10) @(posedge clk_sys);
            end
        end
        $display("detection test done");
        {input_current_limit_select_a, input_current_limit_select_b} <= 2'h0;
        repeat (8) @(posedge clk_sys);
        chk_out({input_current_limit, input_voltage_droop_threshold}, {CPD_INPUT_CURRENT_LIMIT_100, 2'h0});
        {input_current_limit_select_a, input_current_limit_select_b} <= 2'h3;
        repeat (8) @(posedge clk_sys);
        chk_out({input_current_limit, input_voltage_droop_threshold}, {CPD_INPUT_CURRENT_LIMIT_EXT, 2'h3});
        $display("select pin test done");
        battery_good <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wb(CPD_ADDR_DPLUS, 1'b1, 32'h10);
        repeat (3) @(posedge clk_sys);
        chk_out({host_mode, dplus_source_en}, 8'h2);
        attach <= 1'b0;
        repeat (6) @(posedge clk_sys);
        kind <= CPD_PORT_CDP;
        attach <= 1'b1;
        repeat (30) @(posedge clk_sys);
        chk_out(port_type, CPD_PORT_ACA);
        attach <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wb(CPD_ADDR_CTRL, 1'b1, 32'h10);
        kind <= CPD_PORT_CDP;
        attach <= 1'b1;
        wait_for(CPD_PORT_CDP);
        repeat (2) @(posedge clk_sys);
        chk_out(dplus_source_en, 8'h1);
        // Host traffic follows the clear at once, well inside the connect limit
        wb(CPD_ADDR_DPLUS, 1'b1, 32'h10);
        repeat (3) @(posedge clk_sys);
        chk_out(dplus_source_en, 8'h0);
        wb(8'hfc, 1'b1, 32'hff);
        wb(8'hfc, 1'b0, 32'h0); chk_reg(q, 32'h0);
        n = 0;
        while (host_mode !== 1'b0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk_out(host_mode, 8'h0);
        $display("host mode test done");
        close_out();
    end
endmodule
